// >>> hw/sdrbs_pkg.sv
/*
 sdrbs_pkg: command encodings, timing constants and carrier structs for the
 SDRAM refresh and bank-state controller.
 Assumes a 50 MHz single system clock.
*/
package sdrbs_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS          = 20000;
    localparam int PRECHARGE_WAIT_PS      = 20000;
    localparam int ACTIVATE_TO_ACCESS_PS  = 20000;
    localparam int REFRESH_CYCLE_PS       = 66000;
    localparam int MODE_LOAD_WAIT_CLK     = 2;
    localparam int ROW_ACTIVE_MIN_PS      = 44000;
    localparam int SELF_REFRESH_EXIT_PS   = 67000;
    localparam int SELF_REFRESH_EXIT_MIN  = 2;
    localparam int REFRESH_INTERVAL_NS    = 7813;
    localparam int REFRESH_INTERVAL_AUTO_NS = 1953;
    localparam int REFRESH_PER_WINDOW     = 8192;

    function automatic int ceil_clk(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PRECHARGE_WAIT_CLK     = ceil_clk(PRECHARGE_WAIT_PS);
    localparam int ACTIVATE_TO_ACCESS_CLK = ceil_clk(ACTIVATE_TO_ACCESS_PS);
    localparam int REFRESH_CYCLE_CLK      = ceil_clk(REFRESH_CYCLE_PS);
    localparam int ROW_ACTIVE_MIN_CLK     = ceil_clk(ROW_ACTIVE_MIN_PS);
    localparam int SR_EXIT_RAW            = ceil_clk(SELF_REFRESH_EXIT_PS);
    localparam int SELF_REFRESH_EXIT_CLK  = (SR_EXIT_RAW < SELF_REFRESH_EXIT_MIN) ?
                                            SELF_REFRESH_EXIT_MIN : SR_EXIT_RAW;
    // longest interval rounds down
    localparam int REFRESH_INTERVAL_CLK   = (REFRESH_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
    localparam int REFRESH_INTERVAL_AUTO_CLK = (REFRESH_INTERVAL_AUTO_NS * 1000) / CLK_PERIOD_PS;

    localparam int NUM_BANKS = 4;
    localparam int TMR_W     = 9;
    localparam int AUTO_PRECHARGE_BIT = 10;

    // ------------------------------------------------------------
    // command encodings {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_DESELECT  = 4'h8;
    localparam logic [3:0] CMD_NOP       = 4'h7;
    localparam logic [3:0] CMD_ACTIVE    = 4'h3;
    localparam logic [3:0] CMD_READ      = 4'h5;
    localparam logic [3:0] CMD_WRITE     = 4'h4;
    localparam logic [3:0] CMD_BURST_END = 4'h6;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_REFRESH   = 4'h1;
    localparam logic [3:0] CMD_MODE_LOAD = 4'h0;

    // user request opcodes
    typedef enum logic [2:0] {
        SDRBS_OP_ACTIVE    = 3'h0,
        SDRBS_OP_READ      = 3'h1,
        SDRBS_OP_WRITE     = 3'h2,
        SDRBS_OP_PRECHARGE = 3'h3,
        SDRBS_OP_BURST_END = 3'h4,
        SDRBS_OP_MODE_LOAD = 3'h5
    } sdrbs_op_t;

    typedef struct packed {
        sdrbs_op_t   op;
        logic [1:0]  bank;
        logic        auto_precharge_select_bit;
        logic [12:0] addr;
    } sdrbs_req_t;

    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        bank_address_bit1;
        logic        bank_address_bit0;
        logic [12:0] addr;
    } sdrbs_pins_t;

    // per-bank states
    typedef enum logic [5:0] {
        BK_IDLE     = 6'h01,
        BK_ACTIVATE = 6'h02,
        BK_ROW      = 6'h04,
        BK_BURST    = 6'h08,
        BK_BURST_AP = 6'h10,
        BK_PRECHG   = 6'h20
    } sdrbs_bank_t;
endpackage

// >>> hw/sdrbs_bank.sv
/*
 sdrbs_bank: state tracker for one SDRAM bank as seen by the controller.
 Assumes commands arrive only when accepted by the main controller.
*/
`timescale 1ns/1ps
module sdrbs_bank
    import sdrbs_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic act_i,
    input  wire logic rw_i,
    input  wire logic rw_ap_i,
    input  wire logic pre_i,
    input  wire logic burst_end_i,
    output logic      idle_o,
    output logic      row_o,
    output logic      busy_o
);
    sdrbs_bank_t      st_q;
    logic [TMR_W-1:0] tmr_q;

    // ------------------------------------------------------------
    // bank state
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q  <= BK_IDLE;
            tmr_q <= '0;
        end else begin
            if (tmr_q != '0) begin
                tmr_q <= tmr_q - TMR_W'(1);
            end
            case (st_q)
                BK_IDLE: begin
                    if (act_i) begin
                        st_q  <= BK_ACTIVATE;
                        tmr_q <= TMR_W'(ACTIVATE_TO_ACCESS_CLK - 1);
                    end
                end
                BK_ACTIVATE: begin
                    if (tmr_q == '0) begin
                        st_q <= BK_ROW;
                    end
                end
                BK_ROW, BK_BURST: begin
                    if (pre_i) begin
                        st_q  <= BK_PRECHG;
                        tmr_q <= TMR_W'(PRECHARGE_WAIT_CLK - 1);
                    end else if (rw_i && rw_ap_i) begin
                        st_q  <= BK_BURST_AP;
                        tmr_q <= TMR_W'(PRECHARGE_WAIT_CLK - 1);
                    end else if (rw_i) begin
                        st_q <= BK_BURST;
                    end else if (burst_end_i && st_q == BK_BURST) begin
                        st_q <= BK_ROW;
                    end
                end
                BK_BURST_AP, BK_PRECHG: begin
                    if (tmr_q == '0) begin
                        st_q <= BK_IDLE;
                    end
                end
                default: st_q <= BK_IDLE;
            endcase
        end
    end

    assign idle_o = (st_q == BK_IDLE);
    assign row_o  = (st_q == BK_ROW) || (st_q == BK_BURST);
    assign busy_o = (st_q == BK_ACTIVATE) || (st_q == BK_BURST_AP) || (st_q == BK_PRECHG);
endmodule // sdrbs_bank

// >>> hw/sdrbs_ctrl.sv
/*
 sdrbs_ctrl: SDRAM controller for refresh and per-bank command legality.
 Assumes a four-bank SDRAM on the pins and a user issuing requests by valid/ready.
*/
`timescale 1ns/1ps
module sdrbs_ctrl
    import sdrbs_pkg::*;
#(
    parameter bit AUTOMOTIVE = 1'b0
)(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  req_valid_i,
    input  sdrbs_req_t req_i,
    output logic       req_ready_o,
    input  wire logic  sr_req_i,
    output logic       sr_active_o,
    output logic       refresh_busy_o,
    output sdrbs_pins_t pins_o
);
    localparam int RI_CLK = AUTOMOTIVE ? REFRESH_INTERVAL_AUTO_CLK : REFRESH_INTERVAL_CLK;

    typedef enum logic [6:0] {
        S_RUN     = 7'h01,
        S_PREALL  = 7'h02,
        S_REFRESH = 7'h04,
        S_MODE    = 7'h08,
        S_SR      = 7'h10,
        S_SR_EXIT = 7'h20,
        S_WAIT    = 7'h40
    } sdrbs_state_t;

    sdrbs_state_t     st_q;
    logic [TMR_W-1:0] tmr_q;
    logic             ref_due_q;
    logic             sr_pend_q;
    sdrbs_pins_t      pins_q;

    logic [NUM_BANKS-1:0] b_idle, b_row, b_busy;
    logic [NUM_BANKS-1:0] b_act, b_rw, b_pre, b_bt;
    logic                 all_idle, any_busy, accept, pre_all_go;

    // ------------------------------------------------------------
    // bank trackers
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
        sdrbs_bank u_bank (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .act_i      (b_act[i]),
            .rw_i       (b_rw[i]),
            .rw_ap_i    (req_i.auto_precharge_select_bit),
            .pre_i      (b_pre[i]),
            .burst_end_i(b_bt[i]),
            .idle_o     (b_idle[i]),
            .row_o      (b_row[i]),
            .busy_o     (b_busy[i])
        );
    end

    assign all_idle = &b_idle;
    assign any_busy = |b_busy;

    // ------------------------------------------------------------
    // legality of the user request
    // ------------------------------------------------------------
    function automatic logic legal(input sdrbs_req_t r, input logic [NUM_BANKS-1:0] idl,
                                   input logic [NUM_BANKS-1:0] row, input logic busy);
        logic ok;
        ok = 1'b0;
        case (r.op)
            SDRBS_OP_ACTIVE:    ok = idl[r.bank];
            SDRBS_OP_READ,
            SDRBS_OP_WRITE:     ok = row[r.bank];
            SDRBS_OP_PRECHARGE: ok = r.auto_precharge_select_bit ? !busy : !(busy && !idl[r.bank] &&
                                     !row[r.bank]);
            SDRBS_OP_BURST_END: ok = 1'b1;
            SDRBS_OP_MODE_LOAD: ok = &idl;
            default:            ok = 1'b0;
        endcase
        return ok;
    endfunction

    assign accept      = (st_q == S_RUN) && !ref_due_q && !sr_pend_q && req_valid_i &&
                         legal(req_i, b_idle, b_row, any_busy);
    assign req_ready_o = accept;

    always_comb begin
        b_act = '0;
        b_rw  = '0;
        b_pre = '0;
        b_bt  = '0;
        if (accept) begin
            case (req_i.op)
                SDRBS_OP_ACTIVE:    b_act[req_i.bank] = 1'b1;
                SDRBS_OP_READ,
                SDRBS_OP_WRITE:     b_rw[req_i.bank] = 1'b1;
                SDRBS_OP_PRECHARGE: begin
                    if (req_i.auto_precharge_select_bit) begin
                        b_pre = b_row;
                    end else begin
                        b_pre[req_i.bank] = b_row[req_i.bank];
                    end
                end
                SDRBS_OP_BURST_END: b_bt = b_row;
                default: ;
            endcase
        end
        if (pre_all_go) begin
            b_pre = b_row;
        end
    end

    // ------------------------------------------------------------
    // refresh interval timer
    // ------------------------------------------------------------
    logic [15:0] rint_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rint_q    <= '0;
            ref_due_q <= 1'b0;
        end else if (st_q == S_SR) begin
            rint_q    <= '0;
            ref_due_q <= 1'b0;
        end else begin
            if (rint_q == 16'(RI_CLK - 1)) begin
                rint_q    <= '0;
                ref_due_q <= 1'b1;
            end else begin
                rint_q <= rint_q + 16'h0001;
            end
            // clear on the last refresh cycle; a new tick in that cycle wins
            if (st_q == S_REFRESH && (tmr_q == '0 || tmr_q == TMR_W'(1)) &&
                rint_q != 16'(RI_CLK - 1)) begin
                ref_due_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_pend_q <= 1'b0;
        end else begin
            sr_pend_q <= sr_req_i && !AUTOMOTIVE;
        end
    end

    // ------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------
    assign pre_all_go = (st_q == S_RUN) && (ref_due_q || sr_pend_q) && !any_busy && (|b_row);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q   <= S_RUN;
            tmr_q  <= '0;
            pins_q <= '{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                        bank_address_bit1: 1'b0, bank_address_bit0: 1'b0, addr: '0};
        end else begin
            if (tmr_q != '0) begin
                tmr_q <= tmr_q - TMR_W'(1);
            end
            {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_NOP;
            pins_q.addr <= '0;
            case (st_q)
                S_RUN: begin
                    if (pre_all_go) begin
                        {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_PRECHARGE;
                        pins_q.addr[AUTO_PRECHARGE_BIT] <= 1'b1;
                        st_q  <= S_PREALL;
                        tmr_q <= TMR_W'(PRECHARGE_WAIT_CLK);
                    end else if ((ref_due_q || sr_pend_q) && all_idle) begin
                        {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_REFRESH;
                        if (sr_pend_q) begin
                            pins_q.cke <= 1'b0;
                            st_q  <= S_SR;
                            tmr_q <= TMR_W'(ROW_ACTIVE_MIN_CLK);
                        end else begin
                            st_q  <= S_REFRESH;
                            tmr_q <= TMR_W'(REFRESH_CYCLE_CLK - 1);
                        end
                    end else if (accept) begin
                        case (req_i.op)
                            SDRBS_OP_ACTIVE:    {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_ACTIVE;
                            SDRBS_OP_READ:      {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_READ;
                            SDRBS_OP_WRITE:     {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_WRITE;
                            SDRBS_OP_PRECHARGE: {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_PRECHARGE;
                            SDRBS_OP_BURST_END: {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_BURST_END;
                            default:            {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_MODE_LOAD;
                        endcase
                        pins_q.addr <= req_i.addr;
                        if (req_i.op == SDRBS_OP_READ || req_i.op == SDRBS_OP_WRITE ||
                            req_i.op == SDRBS_OP_PRECHARGE) begin
                            pins_q.addr[AUTO_PRECHARGE_BIT] <= req_i.auto_precharge_select_bit;
                        end
                        {pins_q.bank_address_bit1, pins_q.bank_address_bit0} <= req_i.bank;
                        if (req_i.op == SDRBS_OP_MODE_LOAD) begin
                            st_q  <= S_MODE;
                            tmr_q <= TMR_W'(MODE_LOAD_WAIT_CLK - 1);
                        end
                    end
                end
                S_PREALL, S_REFRESH, S_MODE: begin
                    if (tmr_q == '0 || tmr_q == TMR_W'(1)) begin
                        st_q <= (st_q == S_PREALL) ? S_RUN : S_WAIT;
                    end
                end
                S_WAIT: st_q <= S_RUN;
                S_SR: begin
                    {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= CMD_DESELECT;
                    if (tmr_q == '0 && !sr_pend_q) begin
                        pins_q.cke <= 1'b1;
                        st_q  <= S_SR_EXIT;
                        tmr_q <= TMR_W'(SELF_REFRESH_EXIT_CLK - 1);
                    end
                end
                S_SR_EXIT: begin
                    if (tmr_q == '0) begin
                        st_q <= S_RUN;
                    end
                end
                default: st_q <= S_RUN;
            endcase
        end
    end

    assign pins_o         = pins_q;
    assign sr_active_o    = (st_q == S_SR) || (st_q == S_SR_EXIT);
    assign refresh_busy_o = (st_q != S_RUN);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_sr_enter;
        $fell(pins_o.cke);
    endsequence
    property p_sr_cke_low;
        @(posedge clk_i) disable iff (rst_i) s_sr_enter |-> !pins_o.cke [*3];
    endproperty
    a_sr_cke_low: assert property (p_sr_cke_low) else $error("cke rose too early");

    property p_refresh_quiet;
        @(posedge clk_i) disable iff (rst_i)
            (st_q == S_REFRESH) |=> pins_o.cs_n || (pins_o.ras_n && pins_o.cas_n && pins_o.we_n);
    endproperty
    a_refresh_quiet: assert property (p_refresh_quiet) else $error("command during refresh");

    property p_ref_idle;
        @(posedge clk_i) disable iff (rst_i) (st_q == S_RUN && ref_due_q && all_idle && !pre_all_go)
            |=> ({pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} == CMD_REFRESH);
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("refresh not issued");

    property p_no_busy_cmd;
        @(posedge clk_i) disable iff (rst_i) accept |-> !b_busy[req_i.bank] || req_i.op == SDRBS_OP_BURST_END;
    endproperty
    a_no_busy_cmd: assert property (p_no_busy_cmd) else $error("command to busy bank");

    property p_auto_no_sr;
        @(posedge clk_i) disable iff (rst_i) AUTOMOTIVE |-> pins_o.cke;
    endproperty
    a_auto_no_sr: assert property (p_auto_no_sr) else $error("self refresh on automotive");

    property p_ref_addr;
        @(posedge clk_i) disable iff (rst_i)
            ({pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} == CMD_REFRESH) |-> pins_o.addr == '0;
    endproperty
    a_ref_addr: assert property (p_ref_addr) else $error("refresh address not zero");

    property p_sr_exit_nop;
        @(posedge clk_i) disable iff (rst_i) $rose(pins_o.cke) |->
            ({pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} == CMD_DESELECT) ##1
            ({pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} == CMD_NOP) [*2];
    endproperty
    a_sr_exit_nop: assert property (p_sr_exit_nop) else $error("no NOPs after self refresh exit");

    property p_ref_interval;
        @(posedge clk_i) disable iff (rst_i) (rint_q == 16'(RI_CLK - 1) && st_q == S_RUN) |=> ref_due_q;
    endproperty
    a_ref_interval: assert property (p_ref_interval) else $error("refresh not flagged");
endmodule // sdrbs_ctrl

// >>> tb/sdrbs_dev_model.sv
/*
 sdrbs_dev_model: behavioural four-bank device that counts illegal pin activity.
 Assumes pins_i registered by the controller on clk_i, rst_i synchronous.
*/
`timescale 1ns/1ps
module sdrbs_dev_model
    import sdrbs_pkg::*;
#(
    parameter int GAP = 430
)(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  sdrbs_pins_t pins_i,
    output int          viol_o,
    output int          ref_o,
    output logic        self_o
);
    // ------------------------------------------------------------
    // bank states: 0 idle 1 activating 2 row 3 burst 4 ap burst 5 precharging
    // ------------------------------------------------------------
    int st[4], bt[4], gt, sc, gap, b;
    logic cke_q, idle, ex;
    logic [1:0] lb;
    logic [3:0] c;
    task automatic go(input int k, input int s, input int t);
        st[k] = s;
        bt[k] = t;
    endtask
    always @(posedge clk_i) begin
        c = {pins_i.cs_n, pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
        b = {pins_i.bank_address_bit1, pins_i.bank_address_bit0};
        ex = !c[3] && c != CMD_NOP;
        idle = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (bt[i] != 0) begin
                bt[i]--;
                if (bt[i] == 0) st[i] = (st[i] == 1) ? 2 : 0;
            end
            if (st[i] != 0) idle = 1'b0;
        end
        if (gt != 0) gt--;
        if (rst_i) begin
            viol_o = 0;
            ref_o = 0;
            self_o = 0;
            gt = 0;
            gap = 0;
            lb = 2'h0;
            for (int i = 0; i < 4; i++) go(i, 0, 0);
        end else if (self_o) begin
            sc++;
            if (pins_i.cke) begin
                if (sc < ROW_ACTIVE_MIN_CLK || ex) viol_o++;
                self_o = 0;
                gt = SELF_REFRESH_EXIT_CLK;
                gap = 0;
            end
        end else if (!pins_i.cke) begin
            if (cke_q && c == CMD_REFRESH && idle && gt == 0) begin
                self_o = 1;
                sc = 0;
            end else viol_o++;
        end else begin
            gap++;
            if (gap > GAP) viol_o++;
            if (gap > GAP) gap = 0;
            if (ex && gt != 0) viol_o++;
            if (ex) case (c)
                CMD_REFRESH, CMD_MODE_LOAD: begin
                    if (!idle) viol_o++;
                    gt = (c == CMD_REFRESH) ? REFRESH_CYCLE_CLK : MODE_LOAD_WAIT_CLK;
                    if (c == CMD_REFRESH) ref_o++;
                    if (c == CMD_REFRESH) gap = 0;
                end
                CMD_ACTIVE: begin
                    if (st[b] != 0) viol_o++;
                    go(b, 1, ACTIVATE_TO_ACCESS_CLK);
                end
                CMD_READ, CMD_WRITE: begin
                    if (st[b] != 2 && st[b] != 3) viol_o++;
                    lb = b[1:0];
                    if (pins_i.addr[AUTO_PRECHARGE_BIT]) go(b, 4, PRECHARGE_WAIT_CLK);
                    else go(b, 3, 0);
                end
                CMD_PRECHARGE: if (pins_i.addr[AUTO_PRECHARGE_BIT]) begin
                    gt = PRECHARGE_WAIT_CLK;
                    for (int i = 0; i < 4; i++)
                        if (st[i] == 1 || st[i] > 3) viol_o++;
                        else if (st[i] != 0) go(i, 5, PRECHARGE_WAIT_CLK);
                end else if (st[b] == 2 || st[b] == 3) go(b, 5, PRECHARGE_WAIT_CLK);
                else if (st[b] != 0) viol_o++;
                CMD_BURST_END: if (st[lb] == 3) st[lb] = 2;
                default: viol_o++;
            endcase
        end
        cke_q = pins_i.cke;
    end
endmodule // sdrbs_dev_model

// >>> tb/sdram_refresh_bank_state_tb.sv
/*
 sdram_refresh_bank_state_tb: directed and random requests into the standard grade; the automotive grade gets only sr_req_i.
 Assumes the device models flag every illegal pin sequence.
*/
`timescale 1ns/1ps
module sdram_refresh_bank_state_tb;
    import sdrbs_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req_valid_i = 1'b0;
    sdrbs_req_t  req_i = '0;
    logic        sr_req_i = 1'b0;
    logic        req_ready_o, sr_active_o, sr_b, self_a, self_b, taken, busy_a;
    logic        auto_sr_seen = 1'b0;
    sdrbs_pins_t pins_o, pins_b;
    logic [31:0] seed = 32'h2E655F59;
    int          viol_a, viol_b, ref_a, ref_b, fails = 0, total_checks = 0, cyc = 0;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (!rst_i && (sr_b !== 1'b0 || pins_b.cke !== 1'b1)) auto_sr_seen <= 1'b1;
    end
    sdrbs_ctrl #(.AUTOMOTIVE(1'b0)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .sr_req_i(sr_req_i), .sr_active_o(sr_active_o),
        .refresh_busy_o(busy_a), .pins_o(pins_o));
    sdrbs_ctrl #(.AUTOMOTIVE(1'b1)) u_dut_auto (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(1'b0),
        .req_i(req_i), .req_ready_o(), .sr_req_i(sr_req_i), .sr_active_o(sr_b), .refresh_busy_o(),
        .pins_o(pins_b));
    sdrbs_dev_model #(.GAP(REFRESH_INTERVAL_CLK + 40)) u_dev (.clk_i(clk_i), .rst_i(rst_i),
        .pins_i(pins_o), .viol_o(viol_a), .ref_o(ref_a), .self_o(self_a));
    sdrbs_dev_model #(.GAP(REFRESH_INTERVAL_AUTO_CLK + 40)) u_dev_auto (.clk_i(clk_i), .rst_i(rst_i),
        .pins_i(pins_b), .viol_o(viol_b), .ref_o(ref_b), .self_o(self_b));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [3:0] enc(input sdrbs_op_t o);
        case (o)
            SDRBS_OP_ACTIVE:    return CMD_ACTIVE;
            SDRBS_OP_READ:      return CMD_READ;
            SDRBS_OP_WRITE:     return CMD_WRITE;
            SDRBS_OP_PRECHARGE: return CMD_PRECHARGE;
            SDRBS_OP_BURST_END: return CMD_BURST_END;
            default:            return CMD_MODE_LOAD;
        endcase
    endfunction
    task automatic chk_pins(input logic [17:0] got, input logic [17:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic f);
        chk_pins({17'h0, f}, 18'h1);
    endtask
    task automatic issue(input sdrbs_op_t o, input logic [1:0] bk, input logic ap, input logic [12:0] a,
                         input int lim);
        logic [12:0] ad;
        ad = {a[12:11], ap, a[9:0]};
        taken = 1'b0;
        req_i <= '{op: o, bank: bk, auto_precharge_select_bit: ap, addr: ad};
        req_valid_i <= 1'b1;
        for (int n = 0; n < lim && !taken; n++) begin
            @(negedge clk_i);
            taken = (req_ready_o === 1'b1);
            @(posedge clk_i);
        end
        req_valid_i <= 1'b0;
        @(negedge clk_i);
        if (taken) begin
            chk_pins(18'({pins_o.cke, pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n}),
                     18'({1'b1, enc(o)}));
            if (o <= SDRBS_OP_WRITE) chk_pins(18'({pins_o.bank_address_bit1, pins_o.bank_address_bit0, pins_o.addr}),
                                              18'({bk, ad}));
            if (o == SDRBS_OP_PRECHARGE) chk_pins(18'(pins_o.addr[AUTO_PRECHARGE_BIT]), 18'(ap));
        end
        @(posedge clk_i);
    endtask
    task automatic rnd(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            seed = xs(seed);
            issue(sdrbs_op_t'(seed[2:0] % 3'h6), seed[4:3], seed[5], seed[18:6], 12);
            repeat (seed[21:20]) @(posedge clk_i);
        end
    endtask
    task automatic wait_sr(input logic want);
        for (int n = 0; n < 2000 && sr_active_o !== want; n++) @(negedge clk_i);
        chk_flag(sr_active_o === want);
        @(posedge clk_i);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk_pins(18'({pins_o.cke, pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n}),
                 18'({1'b1, CMD_NOP}));
        @(posedge clk_i);
        issue(SDRBS_OP_MODE_LOAD, 2'h0, 1'b0, 13'h0033, 20);
        chk_flag(taken);
        issue(SDRBS_OP_ACTIVE, 2'h1, 1'b0, 13'h0ABC, 20);
        chk_flag(taken);
        issue(SDRBS_OP_ACTIVE, 2'h1, 1'b0, 13'h0123, 8);
        chk_flag(!taken);
        issue(SDRBS_OP_READ, 2'h2, 1'b0, 13'h0010, 8);
        chk_flag(!taken);
        issue(SDRBS_OP_PRECHARGE, 2'h2, 1'b0, 13'h0000, 20);
        chk_flag(taken);
        issue(SDRBS_OP_READ, 2'h1, 1'b0, 13'h0020, 20);
        chk_flag(taken);
        issue(SDRBS_OP_BURST_END, 2'h3, 1'b0, 13'h0000, 20);
        chk_flag(taken);
        issue(SDRBS_OP_PRECHARGE, 2'h0, 1'b1, 13'h0000, 20);
        chk_flag(taken);
        issue(SDRBS_OP_READ, 2'h1, 1'b0, 13'h0020, 8);
        chk_flag(!taken);
        rnd(500);
        @(negedge clk_i);
        chk_flag(ref_a >= (cyc - 20) / (REFRESH_INTERVAL_CLK + 40));
        @(posedge clk_i);
        sr_req_i <= 1'b1;
        wait_sr(1'b1);
        issue(SDRBS_OP_ACTIVE, 2'h0, 1'b0, 13'h0001, 10);
        chk_flag(!taken);
        chk_flag(self_a === 1'b1 && pins_o.cke === 1'b0 && busy_a === 1'b1);
        sr_req_i <= 1'b0;
        wait_sr(1'b0);
        rnd(100);
        sr_req_i <= 1'b1;
        wait_sr(1'b1);
        sr_req_i <= 1'b0;
        wait_sr(1'b0);
        rnd(100);
        @(negedge clk_i);
        chk_flag(viol_a == 0);
        chk_flag(viol_b == 0 && !auto_sr_seen);
        chk_flag(ref_b >= (cyc - 20) / (REFRESH_INTERVAL_AUTO_CLK + 40));
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        end_of_test();
    end
endmodule // sdram_refresh_bank_state_tb
